// File: cpu_branch_bit_ops_core_regs.v
// Core sequencer: bit ops, branches, compare/decrement jumps and core registers.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_core_map.vh"

// Overview of operation
// - OR bit or complement into carry, 2/2.
// - Move bit to carry and back, 2/2.
// - Jump on carry set/clear, 2 bytes 2/3.
// - Jump on bit, bit-clear variant, 3 bytes 3/4.
// - Short relative jump, 2 bytes 3 cycles.
// - Jump to accumulator plus data pointer, 1/3.
// - Jump on accumulator zero/nonzero, 2 bytes 2/3.
// - Compare direct or indirect and jump, 4/5.
// - Compare immediate with accumulator/register, 3/4.
// - Decrement-jump register 2/3, direct 3/4 cycles.
// - Unused opcode behaves as one-cycle no-op.
// - Relative target is next address plus signed offset.
// - Direct below 0x80 is RAM, above SFR.
// - Page target stays in next instruction's 2 kB page.
// - Long target reaches anywhere in program space.
// - Register operands use selected bank of eight.
// - Indirect RAM access addresses through R0 or R1.
// - Two-bit bank select; bank n at 8n.
// - Stack pointer pre-increments on push, resets 0x07.
// - Data pointer bytes at 0x82/0x83, reset zero.
// - Accumulators at 0xE0 and 0xF0, reset zero.
module cpu_branch_bit_ops_core_regs #(
  parameter ADDR_W = 16 // Program address width.
) (
  input wire clk, // System clock, 125 MHz.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire [7:0] code_data, // Program byte at code_addr, same cycle.
  output wire [ADDR_W-1:0] code_addr, // Program fetch address.
  output wire insn_done, // One-cycle pulse after each instruction ends.
  output wire [7:0] arith_primary_reg, // Primary accumulator contents.
  output wire [7:0] stack_pointer, // Stack pointer contents.
  output wire [15:0] data_pointer, // Data pointer, high and low byte.
  output wire carry_flag, // Carry flag.
  output wire [1:0] bank_select_field // Active working-register bank.
);

  // Opcodes handled by the sequencer.
  localparam [7:0] OP_NOP = 8'h00;
  localparam [7:0] OP_LJMP = 8'h02;
  localparam [7:0] OP_JBC = 8'h10;
  localparam [7:0] OP_JB = 8'h20;
  localparam [7:0] OP_JNB = 8'h30;
  localparam [7:0] OP_JC = 8'h40;
  localparam [7:0] OP_JNC = 8'h50;
  localparam [7:0] OP_JZ = 8'h60;
  localparam [7:0] OP_JNZ = 8'h70;
  localparam [7:0] OP_ORL_C = 8'h72;
  localparam [7:0] OP_JMP_IND = 8'h73;
  localparam [7:0] OP_MOV_A_IMM = 8'h74;
  localparam [7:0] OP_MOV_D_IMM = 8'h75;
  localparam [7:0] OP_SJMP = 8'h80;
  localparam [7:0] OP_MOV_BIT_C = 8'h92;
  localparam [7:0] OP_ORL_NC = 8'hA0;
  localparam [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam [7:0] OP_CJNE_AI = 8'hB4;
  localparam [7:0] OP_CJNE_AD = 8'hB5;
  localparam [7:0] OP_PUSH = 8'hC0;
  localparam [7:0] OP_DJNZ_D = 8'hD5;

  // Decodes an opcode into {conditional, length, base cycle count}.
  function [5:0] insn_info;
    input [7:0] op;
    begin
      casez (op)
        OP_ORL_C, OP_ORL_NC, OP_MOV_C_BIT, OP_MOV_BIT_C: insn_info = {1'b0, `LEN_2, `CYC_2};
        OP_JC, OP_JNC, OP_JZ, OP_JNZ: insn_info = {1'b1, `LEN_2, `CYC_2};
        OP_JB, OP_JNB, OP_JBC: insn_info = {1'b1, `LEN_3, `CYC_3};
        OP_SJMP: insn_info = {1'b0, `LEN_2, `CYC_3};
        OP_JMP_IND: insn_info = {1'b0, `LEN_1, `CYC_3};
        OP_CJNE_AD, 8'b1011011?: insn_info = {1'b1, `LEN_3, `CYC_4};
        OP_CJNE_AI, 8'b10111???: insn_info = {1'b1, `LEN_3, `CYC_3};
        8'b11011???: insn_info = {1'b1, `LEN_2, `CYC_2};
        OP_DJNZ_D: insn_info = {1'b1, `LEN_3, `CYC_3};
        OP_LJMP: insn_info = {1'b0, `LEN_3, `CYC_4};
        8'b???00001: insn_info = {1'b0, `LEN_2, `CYC_3};
        OP_MOV_A_IMM, OP_PUSH: insn_info = {1'b0, `LEN_2, `CYC_2};
        OP_MOV_D_IMM: insn_info = {1'b0, `LEN_3, `CYC_3};
        default: insn_info = {1'b0, `LEN_1, `CYC_1}; // Includes 0xA5 and plain no-op.
      endcase
    end
  endfunction

  // Sequencer state.
  reg [2:0] cyc_q; // Cycle index within the current instruction.
  reg ext_q; // High during the extra cycle of a taken branch.
  reg [7:0] op_q; // Latched opcode.
  reg [7:0] b1_q; // Latched second byte.
  reg [7:0] b2_q; // Latched third byte.
  reg [15:0] ipc_q; // Address of the opcode byte.
  reg [15:0] tgt_q; // Target held for the extra cycle.
  reg [15:0] pc_q; // Program counter.
  reg done_q; // Instruction-end pulse.

  // Core registers.
  reg [7:0] sp_q; // Stack pointer.
  reg [7:0] dpl_q; // Data pointer low byte.
  reg [7:0] dph_q; // Data pointer high byte.
  reg [7:0] acc_q; // Primary accumulator.
  reg [7:0] breg_q; // Secondary arithmetic register.
  reg [7:0] psw_q; // Status word: carry and bank select.
  reg [7:0] ram [0:255]; // Internal data RAM; upper half reached only indirectly.

  // Operands, taking the byte straight from the fetch port in the cycle it arrives.
  wire [7:0] op = (cyc_q == 3'h0 && !ext_q) ? code_data : op_q; // Current opcode.
  wire [7:0] o1 = (cyc_q == 3'h1) ? code_data : b1_q; // Second byte.
  wire [7:0] o2 = (cyc_q == 3'h2) ? code_data : b2_q; // Third byte.
  wire [5:0] info = insn_info(op); // Decoded length and count.
  wire [1:0] len = info[4:3]; // Length in bytes.
  wire [2:0] base = info[2:0]; // Not-taken cycle count.
  wire fetch = !ext_q && (cyc_q < {1'b0, len}); // A byte is taken this cycle.
  wire last = !ext_q && (cyc_q == base - 3'h1); // Final not-taken cycle.
  wire [15:0] ipc = (cyc_q == 3'h0) ? pc_q : ipc_q; // Opcode address.
  wire [15:0] nxt = ipc + {14'h0000, len}; // Address of the following instruction.
  wire [7:0] rel = (len == `LEN_3) ? o2 : o1; // Offset is always the last byte.
  wire [15:0] rel_tgt = nxt + {{8{rel[7]}}, rel};
  wire carry = psw_q[`CARRY_POS]; // Carry flag.
  wire [1:0] bank = psw_q[`BANK_HI_POS:`BANK_LO_POS];
  wire [7:0] rn_addr = {3'h0, bank, op[2:0]};
  wire [7:0] ri_ptr = ram[{3'h0, bank, 2'h0, op[0]}]; // Pointer held in R0 or R1.
  wire [7:0] ri_val = ram[ri_ptr]; // Byte that the pointer addresses.
  wire [7:0] rn_val = ram[rn_addr]; // Working register value.
  wire is_bit = (op == OP_ORL_C) || (op == OP_ORL_NC) || (op == OP_MOV_C_BIT) ||
    (op == OP_MOV_BIT_C) || (op == OP_JB) || (op == OP_JNB) || (op == OP_JBC); // Bit operand.
  wire [7:0] bit_byte = o1[`SFR_SPACE_BIT] ? {o1[7:3], 3'h0} : {`BIT_RAM_BASE, o1[6:3]}; // Holder.
  wire [7:0] dir_addr = is_bit ? bit_byte : o1; // Direct address read this instruction.

  // Direct-space read: low half is RAM, high half the SFRs.
  reg [7:0] dir_val;
  always @*
  begin
    if (!dir_addr[`SFR_SPACE_BIT])
      dir_val = ram[dir_addr];
    else
    begin
      case (dir_addr)
        `SP_ADDR: dir_val = sp_q;
        `DPL_ADDR: dir_val = dpl_q;
        `DPH_ADDR: dir_val = dph_q;
        `PSW_ADDR: dir_val = psw_q;
        `ACC_ADDR: dir_val = acc_q;
        `BREG_ADDR: dir_val = breg_q;
        default: dir_val = 8'h00; // Unmapped SFRs read as zero.
      endcase
    end
  end

  wire bitv = dir_val[o1[2:0]]; // Addressed bit.

  // Execution decode: write-back, carry update and branch decision.
  reg wr_en; // Write-back requested.
  reg wr_ind; // Write goes to RAM by plain index, not the direct map.
  reg [7:0] wr_addr; // Write address.
  reg [7:0] wr_data; // Write data.
  reg c_en; // Carry update requested.
  reg c_val; // New carry.
  reg taken; // Conditional branch condition holds.
  reg jump; // Unconditional jump.
  reg push; // Stack push.
  reg [15:0] jtgt; // Branch target.
  reg [7:0] cmp_a; // Compare left operand.
  reg [7:0] cmp_b; // Compare right operand.
  reg [7:0] dec; // Decremented value.
  always @*
  begin
    wr_en = 1'b0;
    wr_ind = 1'b0;
    wr_addr = dir_addr;
    wr_data = dir_val;
    c_en = 1'b0;
    c_val = carry;
    taken = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    jtgt = rel_tgt;
    cmp_a = acc_q;
    cmp_b = o1;
    dec = 8'h00;
    casez (op)
      OP_ORL_C:
      begin
        c_en = 1'b1;
        c_val = carry | bitv;
      end
      OP_ORL_NC:
      begin
        c_en = 1'b1;
        c_val = carry | ~bitv;
      end
      OP_MOV_C_BIT:
      begin
        c_en = 1'b1;
        c_val = bitv;
      end
      OP_MOV_BIT_C:
      begin
        wr_en = 1'b1;
        wr_data[o1[2:0]] = carry;
      end
      OP_JC: taken = carry;
      OP_JNC: taken = !carry;
      OP_JB: taken = bitv;
      OP_JNB: taken = !bitv;
      OP_JBC:
      begin
        taken = bitv;
        wr_en = bitv;
        wr_data[o1[2:0]] = 1'b0;
      end
      OP_JZ: taken = (acc_q == 8'h00);
      OP_JNZ: taken = (acc_q != 8'h00);
      OP_CJNE_AI, OP_CJNE_AD, 8'b1011011?, 8'b10111???:
      begin
        if (op == OP_CJNE_AD)
          cmp_b = dir_val;
        else if (op[3:1] == 3'h3)
          cmp_a = ri_val;
        else if (op[3])
          cmp_a = rn_val;
        // Every form but the direct one compares against the immediate second byte.
        taken = (cmp_a != cmp_b);
        c_en = 1'b1;
        c_val = (cmp_a < cmp_b);
      end
      8'b11011???:
      begin
        dec = rn_val - 8'h01;
        wr_en = 1'b1;
        wr_ind = 1'b1;
        wr_addr = rn_addr;
        wr_data = dec;
        taken = (dec != 8'h00);
      end
      OP_DJNZ_D:
      begin
        dec = dir_val - 8'h01;
        wr_en = 1'b1;
        wr_data = dec;
        taken = (dec != 8'h00);
      end
      OP_SJMP: jump = 1'b1;
      OP_JMP_IND:
      begin
        jump = 1'b1;
        jtgt = {dph_q, dpl_q} + {8'h00, acc_q};
      end
      OP_LJMP:
      begin
        jump = 1'b1;
        jtgt = {o1, o2};
      end
      8'b???00001:
      begin
        jump = 1'b1;
        jtgt = {nxt[15:11], op[7:5], o1};
      end
      OP_MOV_A_IMM:
      begin
        wr_en = 1'b1;
        wr_addr = `ACC_ADDR;
        wr_data = o1;
      end
      OP_MOV_D_IMM:
      begin
        wr_en = 1'b1;
        wr_data = o2;
      end
      OP_PUSH:
      begin
        push = 1'b1;
        wr_en = 1'b1;
        wr_ind = 1'b1;
        wr_addr = sp_q + 8'h01;
      end
      default: taken = 1'b0; // No-op and unused opcodes change nothing.
    endcase
  end

  wire exec = last; // Effects take place in the final not-taken cycle.
  wire ram_wr = exec && wr_en && (wr_ind || !wr_addr[`SFR_SPACE_BIT]);

  // Internal RAM write port; contents are not reset.
  always @(posedge clk)
  begin
    if (ram_wr)
      ram[wr_addr] <= wr_data;
  end

  // Sequencer and core registers.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cyc_q <= 3'h0;
      ext_q <= 1'b0;
      op_q <= OP_NOP;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      ipc_q <= 16'h0000;
      tgt_q <= 16'h0000;
      pc_q <= 16'h0000;
      done_q <= 1'b0;
      sp_q <= `SP_RESET;
      dpl_q <= `ZERO_RESET;
      dph_q <= `ZERO_RESET;
      acc_q <= `ZERO_RESET;
      breg_q <= `ZERO_RESET;
      psw_q <= `ZERO_RESET;
    end
    else if (ext_q)
    begin
      // Extra cycle of a taken branch: load the target.
      pc_q <= tgt_q;
      ext_q <= 1'b0;
      cyc_q <= 3'h0;
      done_q <= 1'b1;
    end
    else
    begin
      // Latch each instruction byte as it is fetched.
      if (fetch)
        pc_q <= pc_q + 16'h0001;
      if (cyc_q == 3'h0)
      begin
        op_q <= code_data;
        ipc_q <= pc_q;
      end
      if (cyc_q == 3'h1)
        b1_q <= code_data;
      if (cyc_q == 3'h2)
        b2_q <= code_data;
      if (exec)
      begin
        // Direct write into the SFR half of the space.
        if (wr_en && !wr_ind && wr_addr[`SFR_SPACE_BIT])
        begin
          case (wr_addr)
            `SP_ADDR: sp_q <= wr_data;
            `DPL_ADDR: dpl_q <= wr_data;
            `DPH_ADDR: dph_q <= wr_data;
            `PSW_ADDR: psw_q <= wr_data;
            `ACC_ADDR: acc_q <= wr_data;
            `BREG_ADDR: breg_q <= wr_data;
            default: psw_q <= psw_q; // Unmapped SFR writes are dropped.
          endcase
        end
        if (push)
          sp_q <= sp_q + 8'h01;
        if (c_en)
          psw_q[`CARRY_POS] <= c_val;
        if (jump)
          pc_q <= jtgt;
        if (info[5] && taken)
        begin
          // Taken conditional branch costs one more cycle.
          ext_q <= 1'b1;
          tgt_q <= rel_tgt;
          done_q <= 1'b0;
        end
        else
        begin
          cyc_q <= 3'h0;
          done_q <= 1'b1;
        end
      end
      else
      begin
        cyc_q <= cyc_q + 3'h1;
        done_q <= 1'b0;
      end
    end
  end

  // Outputs straight from registers.
  assign code_addr = pc_q[ADDR_W-1:0];
  assign insn_done = done_q;
  assign arith_primary_reg = acc_q;
  assign stack_pointer = sp_q;
  assign data_pointer = {dph_q, dpl_q};
  assign carry_flag = carry;
  assign bank_select_field = bank;

endmodule
`default_nettype wire

// File: cpu_branch_bit_ops_core_regs_tb.sv
// Testbench that runs a program through the core and checks timing, targets and registers.
`timescale 1ns/1ns
`default_nettype none
module cpu_branch_bit_ops_core_regs_tb;
  typedef struct {logic [15:0] nx; int c; int s; logic [15:0] v;} step_t; // One instruction.
  logic clk = 1'b0; // System clock.
  logic sys_rst = 1'b1; // Reset, held from time zero.
  logic [7:0] code_data; // Byte returned by the program store.
  logic [7:0] rom [0:65535]; // Program store, read without delay.
  wire [15:0] code_addr; // Fetch address.
  wire insn_done; // Instruction end pulse.
  wire [7:0] arith_primary_reg; // Accumulator.
  wire [7:0] stack_pointer; // Stack pointer.
  wire [15:0] data_pointer; // Data pointer.
  wire carry_flag; // Carry flag.
  wire [1:0] bank_select_field; // Active bank.
  step_t plan [$]; // Expected outcome of each instruction in execution order.
  int miscompares = 0; // Mismatches seen.
  int tests_run = 0; // Comparisons made.
  int cnt; // Cycles counted for one instruction.
  // The store answers in the same cycle, as the fetch port needs.
  assign code_data = rom[code_addr];
  // The clock toggles every 4 ns, half of the 8 ns period.
  always #4 clk = ~clk;
  cpu_branch_bit_ops_core_regs #(.ADDR_W(16)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .code_data(code_data), .code_addr(code_addr), .insn_done(insn_done),
    .arith_primary_reg(arith_primary_reg), .stack_pointer(stack_pointer),
    .data_pointer(data_pointer), .carry_flag(carry_flag), .bank_select_field(bank_select_field));
  // Compares a seen value with the expected one and reports a difference.
  task check(input [15:0] seen, input [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Places an instruction in the store and records its cycles, next address and a register.
  task i(input [15:0] a, input int n, input [23:0] b, input int c, input [15:0] nx,
    input int s = 0, input [15:0] v = 16'h0000);
    step_t e;
    for (int k = 0; k < n; k++) rom[a + k] = b[23 - 8 * k -: 8];
    e.nx = nx;
    e.c = c;
    e.s = s;
    e.v = v;
    plan.push_back(e);
  endtask
  // Picks the register output named by a selector code.
  function automatic [15:0] selv(input int s);
    case (s)
      1: selv = {8'h00, arith_primary_reg};
      2: selv = {8'h00, stack_pointer};
      3: selv = data_pointer;
      4: selv = {15'h0000, carry_flag};
      default: selv = {14'h0000, bank_select_field};
    endcase
  endfunction
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hang short well after the program should have ended.
  initial
  begin
    #20000;
    miscompares++;
    end_sim;
  end
  // Main sequence: load the program, reset, then follow every instruction.
  initial
  begin
    for (int k = 0; k < 65536; k++) rom[k] = 8'h00;
    i(16'h0000, 1, 24'hA50000, 1, 16'h0001);
    i(16'h0001, 1, 24'h000000, 1, 16'h0002);
    i(16'h0002, 2, 24'h600200, 3, 16'h0006);
    i(16'h0006, 2, 24'h700500, 2, 16'h0008);
    i(16'h0008, 2, 24'h745A00, 2, 16'h000A, 1, 16'h005A);
    i(16'h000A, 2, 24'h800400, 3, 16'h0010);
    i(16'h0010, 2, 24'h70FA00, 3, 16'h000C);
    i(16'h000C, 2, 24'h800600, 3, 16'h0014);
    i(16'h0014, 3, 24'hB46000, 4, 16'h0017, 4, 16'h0001);
    i(16'h0017, 2, 24'h400000, 3, 16'h0019);
    i(16'h0019, 2, 24'h500000, 2, 16'h001B);
    i(16'h001B, 3, 24'hB45A00, 3, 16'h001E, 4, 16'h0000);
    i(16'h001E, 2, 24'h400000, 2, 16'h0020);
    i(16'h0020, 3, 24'h75D018, 3, 16'h0023, 5, 16'h0003);
    i(16'h0023, 3, 24'h751B02, 3, 16'h0026);
    i(16'h0026, 2, 24'hDB0000, 3, 16'h0028);
    i(16'h0028, 2, 24'hDB0000, 2, 16'h002A);
    i(16'h002A, 3, 24'h753001, 3, 16'h002D);
    i(16'h002D, 3, 24'hD53000, 3, 16'h0030);
    i(16'h0030, 3, 24'hD53000, 4, 16'h0033);
    i(16'h0033, 3, 24'h758140, 3, 16'h0036, 2, 16'h0040);
    i(16'h0036, 2, 24'hC0E000, 2, 16'h0038, 2, 16'h0041);
    i(16'h0038, 3, 24'h758240, 3, 16'h003B);
    i(16'h003B, 3, 24'h758300, 3, 16'h003E, 3, 16'h0040);
    i(16'h003E, 2, 24'h740200, 2, 16'h0040);
    i(16'h0040, 1, 24'h730000, 3, 16'h0042);
    i(16'h0042, 3, 24'h0207FE, 4, 16'h07FE);
    i(16'h07FE, 2, 24'h012000, 3, 16'h0820);
    i(16'h0820, 3, 24'h75F033, 3, 16'h0823);
    i(16'h0823, 3, 24'hB5F000, 5, 16'h0826, 4, 16'h0001);
    i(16'h0826, 2, 24'h743300, 2, 16'h0828);
    i(16'h0828, 3, 24'hB5F000, 4, 16'h082B, 4, 16'h0000);
    i(16'h082B, 2, 24'h72E100, 2, 16'h082D, 4, 16'h0001);
    i(16'h082D, 2, 24'hA2E200, 2, 16'h082F, 4, 16'h0000);
    i(16'h082F, 2, 24'hA0E200, 2, 16'h0831, 4, 16'h0001);
    i(16'h0831, 2, 24'h92E700, 2, 16'h0833, 1, 16'h00B3);
    i(16'h0833, 3, 24'h20E000, 4, 16'h0836);
    i(16'h0836, 3, 24'h30E000, 3, 16'h0839);
    i(16'h0839, 3, 24'h10E000, 4, 16'h083C, 1, 16'h00B2);
    i(16'h083C, 3, 24'h10E000, 3, 16'h083F);
    i(16'h083F, 3, 24'h751830, 3, 16'h0842);
    i(16'h0842, 3, 24'hB6FF00, 4, 16'h0845);
    i(16'h0845, 3, 24'hB60000, 5, 16'h0848);
    i(16'h0848, 3, 24'hBB0000, 3, 16'h084B);
    i(16'h084B, 2, 24'h80FE00, 3, 16'h084B);
    @(posedge clk);
    #1;
    check({arith_primary_reg, stack_pointer}, 16'h0007);
    check(data_pointer, 16'h0000);
    check({13'h0000, carry_flag, bank_select_field}, 16'h0000);
    check(code_addr, 16'h0000);
    @(posedge clk);
    @(posedge clk);
    sys_rst <= 1'b0;
    // Each instruction begins in the same cycle as the previous end pulse.
    foreach (plan[j])
    begin
      cnt = 0;
      do
      begin
        @(posedge clk);
        #1;
        cnt++;
      end while (insn_done !== 1'b1 && cnt < 8);
      check(16'(cnt), 16'(plan[j].c));
      check(code_addr, plan[j].nx);
      if (plan[j].s != 0)
        check(selv(plan[j].s), plan[j].v);
    end
    end_sim;
  end
endmodule
`default_nettype wire

// File: cpu_core_checker_sva.sv
// Concurrent checks on the core's fetch port, branch timing and register outputs.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_checker #(
  parameter ADDR_W = 16 // Program address width.
) (
  input wire clk, // System clock.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire [7:0] code_data, // Program byte seen by the core.
  input wire [ADDR_W-1:0] code_addr, // Fetch address.
  input wire insn_done, // Instruction end pulse.
  input wire [7:0] arith_primary_reg, // Accumulator.
  input wire [7:0] stack_pointer, // Stack pointer.
  input wire [15:0] data_pointer, // Data pointer.
  input wire carry_flag, // Carry flag.
  input wire [1:0] bank_select_field // Active bank.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  reg first_q; // High in the first cycle after reset, when the first opcode is taken.
  reg [7:0] d1_q, d2_q, d3_q; // Program byte history.
  reg [ADDR_W-1:0] a1_q, a2_q, a3_q; // Fetch address history.
  wire opc = insn_done | first_q; // An opcode is being taken in this cycle.
  wire [7:0] op = code_data; // Byte under fetch.
  wire [15:0] nxt3 = a3_q + 16'h0002; // Address after a 2-byte opcode taken 3 cycles ago.
  wire cnd = opc && (op == 8'h40 || op == 8'h50 || op == 8'h60 || op == 8'h70); // Flag jumps.
  wire tk = (op == 8'h40 && carry_flag) || (op == 8'h50 && !carry_flag) ||
    (op == 8'h60 && arith_primary_reg == 8'h00) || (op == 8'h70 && arith_primary_reg != 8'h00);
  // The history registers remember what was fetched over the last three cycles.
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      first_q <= 1'b1;
      {d1_q, d2_q, d3_q} <= 24'h000000;
      {a1_q, a2_q, a3_q} <= {3 * ADDR_W{1'b0}};
    end
    else
    begin
      first_q <= 1'b0;
      {d1_q, d2_q, d3_q} <= {code_data, d1_q, d2_q};
      {a1_q, a2_q, a3_q} <= {code_addr, a1_q, a2_q};
    end
  end
  property p_nop;
    opc && (op == 8'h00 || op == 8'hA5) |=> insn_done && code_addr == a1_q + 1'b1;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op timing wrong");
  property p_sjmp;
    opc && op == 8'h80 |=> !insn_done ##1 !insn_done ##1
      (insn_done && code_addr == nxt3 + {{8{d2_q[7]}}, d2_q});
  endproperty
  a_sjmp: assert property (p_sjmp) else $error("short jump wrong");
  property p_ljmp;
    opc && op == 8'h02 |=> !insn_done [*3] ##1 (insn_done && code_addr == {d3_q, d2_q});
  endproperty
  a_ljmp: assert property (p_ljmp) else $error("long jump wrong");
  property p_ajmp;
    opc && op[4:0] == 5'h01 |=> !insn_done ##1 !insn_done ##1
      (insn_done && code_addr == {nxt3[15:11], d3_q[7:5], d2_q});
  endproperty
  a_ajmp: assert property (p_ajmp) else $error("page jump wrong");
  property p_br_tk;
    cnd && tk |=> !insn_done ##1 !insn_done ##1 insn_done;
  endproperty
  a_br_tk: assert property (p_br_tk) else $error("taken jump count wrong");
  property p_br_nt;
    cnd && !tk |=> !insn_done ##1 insn_done;
  endproperty
  a_br_nt: assert property (p_br_nt) else $error("untaken jump count wrong");
  property p_bit;
    opc && (op == 8'h72 || op == 8'hA0 || op == 8'hA2 || op == 8'h92) |=> !insn_done ##1 insn_done;
  endproperty
  a_bit: assert property (p_bit) else $error("carry bit op count wrong");
  property p_jmpa;
    opc && op == 8'h73 |=> !insn_done ##1 !insn_done ##1
      (insn_done && code_addr == data_pointer + {8'h00, $past(arith_primary_reg, 3)});
  endproperty
  a_jmpa: assert property (p_jmpa) else $error("indirect jump wrong");
  property p_push;
    opc && op == 8'hC0 |=> !insn_done ##1
      (insn_done && stack_pointer == $past(stack_pointer, 2) + 8'h01);
  endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_rst;
    $fell(sys_rst) |-> stack_pointer == 8'h07 && data_pointer == 16'h0000 &&
      arith_primary_reg == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind cpu_branch_bit_ops_core_regs cpu_core_checker #(.ADDR_W(ADDR_W)) i_chk (.clk(clk),
  .sys_rst(sys_rst), .code_data(code_data), .code_addr(code_addr), .insn_done(insn_done),
  .arith_primary_reg(arith_primary_reg), .stack_pointer(stack_pointer),
  .data_pointer(data_pointer), .carry_flag(carry_flag), .bank_select_field(bank_select_field));
`default_nettype wire

// File: cpu_core_map.vh
// Register addresses, field positions, reset values and cycle counts of the core.
`ifndef CPU_CORE_MAP_VH
`define CPU_CORE_MAP_VH

// Direct addresses of the core special-function registers.
`define SP_ADDR 8'h81
`define DPL_ADDR 8'h82
`define DPH_ADDR 8'h83
`define PSW_ADDR 8'hD0
`define ACC_ADDR 8'hE0
`define BREG_ADDR 8'hF0

// Reset values.
`define SP_RESET 8'h07
`define ZERO_RESET 8'h00

// Status word fields: carry flag and bank select.
`define CARRY_POS 7
`define BANK_HI_POS 4
`define BANK_LO_POS 3

// Bit-addressable RAM starts here; direct addresses from this bit upward are SFRs.
`define BIT_RAM_BASE 4'h2
`define SFR_SPACE_BIT 7

// Instruction lengths in bytes.
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3

// Base cycle counts; a taken conditional branch adds one more cycle.
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4

`endif
